/* File: tct_pkg.sv */
package tct_pkg;

  // Register byte offsets; the printed offsets are not all multiples of four, so they are
  // kept as indices and the byte address is four times the index.
  localparam logic [7:0] TIMER0_CONTROL_INDEX = 8'h56;
  localparam logic [7:0] TIMER1_CONTROL_INDEX = 8'h5E;
  localparam logic [7:0] TIMER2_CONTROL_INDEX = 8'h66;
  // Compare and count registers, indices taken from the neighbouring register map.
  localparam logic [7:0] TIMER0_COUNT_INDEX = 8'h50;
  localparam logic [7:0] TIMER0_COMPARE_A_INDEX = 8'h52;
  localparam logic [7:0] TIMER0_COMPARE_B_INDEX = 8'h54;
  localparam logic [7:0] TIMER1_COUNT_INDEX = 8'h58;
  localparam logic [7:0] TIMER1_COMPARE_A_INDEX = 8'h5A;
  localparam logic [7:0] TIMER1_COMPARE_B_INDEX = 8'h5C;
  localparam logic [7:0] TIMER2_COUNT_INDEX = 8'h60;
  localparam logic [7:0] TIMER2_COMPARE_A_INDEX = 8'h62;

  // Control field positions.
  localparam int ENABLE_BIT = 15;
  localparam int GATE_BIT = 14;
  localparam int INTERRUPT_ENABLE_BIT = 13;
  localparam int COMPARE_SELECT_BIT = 12;
  localparam int MAX_COUNT_BIT = 5;
  localparam int RETRIGGER_BIT = 4;
  localparam int PRESCALE_BIT = 3;
  localparam int EXTERNAL_CLOCK_BIT = 2;
  localparam int DUAL_COMPARE_BIT = 1;
  localparam int CONTINUOUS_BIT = 0;

  // Reset value of every control register.
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // Internal clocking advances a timer once every this many clocks.
  localparam int INTERNAL_DIVIDE = 4;
  localparam logic [1:0] DIVIDE_LAST = 2'(INTERNAL_DIVIDE - 1);

  // Avalon read data for an unmapped address.
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

/* File: tct_tick_if.sv */
`timescale 1ns/100ps
// Carries per-timer stepping signals between the top and a timer core.
interface tct_tick_if;
  logic step; // Count advances this cycle.
  logic hold; // Gate input holds the count.
  logic retrigger; // Rising edge on the input resets the count.
  logic reached; // Count met the active compare this cycle.
  modport top (output step, output hold, output retrigger, input reached);
  modport core (input step, input hold, input retrigger, output reached);
endinterface

/* File: tct_core.sv */
`timescale 1ns/100ps
// One timer core: counter, dual compare sequencing and max-count detection.
module tct_core (
  input wire logic clock,
  input wire logic resetn,
  tct_tick_if.core tick,
  input wire logic enable,
  input wire logic dual_compare_mode,
  input wire logic [15:0] compare_a,
  input wire logic [15:0] compare_b,
  output logic [15:0] count,
  output logic compare_select_flag
);

  // Active compare value; B only when dual compare mode selects it.
  logic [15:0] limit;
  // Value the count takes on this step; it wraps from all ones back to zero.
  logic [15:0] next_count;

  always_comb begin
    limit = (compare_select_flag && dual_compare_mode) ? compare_b : compare_a;
    next_count = count + 16'h0001;
  end

  // The step that brings the count to the compare value clears it instead, so a compare
  // of N takes N steps; a compare of zero is met only on the wrap from all ones, which
  // gives the full sixteen-bit range without a special case.
  assign tick.reached = enable && tick.step && !tick.hold && (next_count == limit);

  // Counter: holds while disabled or gated, clears at compare or on retrigger.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= 16'h0000;
    end else if (enable && tick.retrigger) begin
      count <= 16'h0000;
    end else if (tick.reached) begin
      count <= 16'h0000;
    end else if (enable && tick.step && !tick.hold) begin
      count <= next_count;
    end
  end

  // Compare select toggles A to B and back in dual mode, stays on A otherwise.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      compare_select_flag <= 1'b0;
    end else if (!dual_compare_mode) begin
      compare_select_flag <= 1'b0;
    end else if (tick.reached) begin
      compare_select_flag <= !compare_select_flag;
    end
  end

endmodule

/* File: tct_timer_control.sv */
`timescale 1ns/100ps
module tct_timer_control (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic timer_input_zero,
  input wire logic timer_input_one,
  output logic [2:0] interrupt_request
);

  // Word index of the access; the bus carries byte addresses.
  logic [7:0] index;
  assign index = address[9:2];

  // Stored control bits per timer, compare values and two-stage input synchronisers.
  logic [15:0] control [3];
  logic [15:0] compare_a [3];
  logic [15:0] compare_b [2];
  logic [15:0] count [3];
  logic [2:0] compare_select_flag;
  logic [2:0] reached;
  logic [1:0] input_meta;
  logic [1:0] input_sync;
  logic [1:0] input_last;
  logic [1:0] divider;
  logic answered;

  // Every access is answered one cycle after it appears; the spare cycle lets the read
  // data come from a flop, which keeps the bus timing independent of decode depth.
  assign waitrequest = (read || write) && !answered;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      answered <= 1'b0;
    end else begin
      answered <= (read || write) && !answered;
    end
  end

  // A write is taken in the same cycle that waitrequest drops.
  logic write_taken;
  assign write_taken = write && answered;

  // Low half-word byte lanes; the upper lanes carry nothing and are ignored.
  function automatic logic [15:0] lane_mask(input logic [3:0] enables);
    lane_mask = {{8{enables[1]}}, {8{enables[0]}}};
  endfunction

  // Merge written bytes into an old value.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] enables);
    merge = (old & ~lane_mask(enables)) | (data[15:0] & lane_mask(enables));
  endfunction

  // Internal prescaler: one step every fourth clock, shared by timer two and by full timers that are neither external nor prescaled.
  logic internal_step;
  assign internal_step = (divider == tct_pkg::DIVIDE_LAST);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      divider <= 2'h0;
    end else begin
      divider <= divider + 2'h1;
    end
  end

  // The first stage feeds only the second; edges are found on the second and third.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      input_meta <= 2'h0;
      input_sync <= 2'h0;
      input_last <= 2'h0;
    end else begin
      input_meta <= {timer_input_one, timer_input_zero};
      input_sync <= input_meta;
      input_last <= input_sync;
    end
  end

  logic [1:0] input_rise;
  assign input_rise = input_sync & ~input_last;

  // Stepping interfaces, one per timer core.
  tct_tick_if tick [3] ();

  // Step selection for the two full timers.
  generate
    for (genvar t = 0; t < 2; t++) begin : full_step
      logic external;
      assign external = control[t][tct_pkg::EXTERNAL_CLOCK_BIT];
      // External clocking counts input edges and ignores retrigger and prescale.
      assign tick[t].step = external ? input_rise[t] :
                            (control[t][tct_pkg::PRESCALE_BIT] ? reached[2] :
                             internal_step);
      // Gate mode: a low input holds the count.
      assign tick[t].hold = !external && !control[t][tct_pkg::RETRIGGER_BIT]
                            && !input_sync[t];
      // Retrigger mode: a rising input edge zeroes the count.
      assign tick[t].retrigger = !external && control[t][tct_pkg::RETRIGGER_BIT]
                                 && input_rise[t];
    end
  endgenerate

  // Timer two always runs on the internal divider, ungated.
  assign tick[2].step = internal_step;
  assign tick[2].hold = 1'b0;
  assign tick[2].retrigger = 1'b0;

  // The cores; timer two has no second compare, so B mirrors A and dual mode stays off.
  generate
    for (genvar t = 0; t < 3; t++) begin : core
      tct_core timer (
        .clock(clock),
        .resetn(resetn),
        .tick(tick[t]),
        .enable(control[t][tct_pkg::ENABLE_BIT]),
        .dual_compare_mode(t < 2 ? control[t][tct_pkg::DUAL_COMPARE_BIT] : 1'b0),
        .compare_a(compare_a[t]),
        .compare_b(t < 2 ? compare_b[t % 2] : compare_a[t]),
        .count(count[t]),
        .compare_select_flag(compare_select_flag[t])
      );
      assign reached[t] = tick[t].reached;
    end
  endgenerate

  // Control index of a timer.
  function automatic logic [7:0] control_index(input int t);
    control_index = (t == 0) ? tct_pkg::TIMER0_CONTROL_INDEX :
                    (t == 1) ? tct_pkg::TIMER1_CONTROL_INDEX :
                    tct_pkg::TIMER2_CONTROL_INDEX;
  endfunction

  // Control registers: enable only under the gate, sticky max flag, one-shot stop.
  // Hardware setting of the max flag wins over a software clear in the same cycle.
  generate
    for (genvar t = 0; t < 3; t++) begin : control_reg
      logic hit;
      logic end_of_run;
      logic [15:0] written;
      assign hit = write_taken && (index == control_index(t));
      assign written = merge(control[t], writedata, byteenable);
      // A run ends at A in single mode, or after B in dual mode.
      assign end_of_run = reached[t] && (t == 2 || !control[t][tct_pkg::DUAL_COMPARE_BIT]
                                         || compare_select_flag[t]);
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          control[t] <= tct_pkg::CONTROL_RESET;
        end else begin
          if (hit) begin
            // Mode bits only for full timers; timer two keeps interrupt and continuous.
            control[t][13] <= written[13];
            control[t][tct_pkg::CONTINUOUS_BIT] <= written[tct_pkg::CONTINUOUS_BIT];
            if (t < 2) begin
              control[t][4:1] <= written[4:1];
            end
            if (writedata[tct_pkg::GATE_BIT] && byteenable[1]) begin
              control[t][tct_pkg::ENABLE_BIT] <= writedata[tct_pkg::ENABLE_BIT];
            end
            if (!written[tct_pkg::MAX_COUNT_BIT]) begin
              control[t][tct_pkg::MAX_COUNT_BIT] <= 1'b0;
            end
          end
          if (reached[t]) begin
            control[t][tct_pkg::MAX_COUNT_BIT] <= 1'b1;
          end
          if (end_of_run && !control[t][tct_pkg::CONTINUOUS_BIT]) begin
            control[t][tct_pkg::ENABLE_BIT] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Interrupt request pulses at each compare when enabled; its latching in the
  // interrupt controller keeps it pending even if the timer is disabled later.
  generate
    for (genvar t = 0; t < 3; t++) begin : irq
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          interrupt_request[t] <= 1'b0;
        end else begin
          interrupt_request[t] <= reached[t]
                                  && control[t][tct_pkg::INTERRUPT_ENABLE_BIT];
        end
      end
    end
  endgenerate

  // Compare registers take writes; they have no defined reset value, zero is used.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      compare_a[0] <= 16'h0000;
      compare_a[1] <= 16'h0000;
      compare_a[2] <= 16'h0000;
      compare_b[0] <= 16'h0000;
      compare_b[1] <= 16'h0000;
    end else if (write_taken) begin
      unique case (index)
        tct_pkg::TIMER0_COMPARE_A_INDEX: compare_a[0] <= merge(compare_a[0], writedata, byteenable);
        tct_pkg::TIMER1_COMPARE_A_INDEX: compare_a[1] <= merge(compare_a[1], writedata, byteenable);
        tct_pkg::TIMER2_COMPARE_A_INDEX: compare_a[2] <= merge(compare_a[2], writedata, byteenable);
        tct_pkg::TIMER0_COMPARE_B_INDEX: compare_b[0] <= merge(compare_b[0], writedata, byteenable);
        tct_pkg::TIMER1_COMPARE_B_INDEX: compare_b[1] <= merge(compare_b[1], writedata, byteenable);
        default: begin
        end
      endcase
    end
  end

  // Control read view: enable visible, gate always zero, reserved bits zero.
  function automatic logic [31:0] control_view(input logic [15:0] value, input logic sel);
    logic [15:0] shown;
    shown = value & 16'hA03F;
    shown[tct_pkg::COMPARE_SELECT_BIT] = sel;
    shown[tct_pkg::GATE_BIT] = 1'b0;
    control_view = {16'h0000, shown};
  endfunction

  // Read data is registered and stands with the cycle in which waitrequest drops.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if (read && !answered) begin
      unique case (index)
        tct_pkg::TIMER0_CONTROL_INDEX: readdata <= control_view(control[0], compare_select_flag[0]);
        tct_pkg::TIMER1_CONTROL_INDEX: readdata <= control_view(control[1], compare_select_flag[1]);
        tct_pkg::TIMER2_CONTROL_INDEX: readdata <= control_view(control[2] & 16'hE021, 1'b0);
        tct_pkg::TIMER0_COUNT_INDEX: readdata <= {16'h0000, count[0]};
        tct_pkg::TIMER1_COUNT_INDEX: readdata <= {16'h0000, count[1]};
        tct_pkg::TIMER2_COUNT_INDEX: readdata <= {16'h0000, count[2]};
        tct_pkg::TIMER0_COMPARE_A_INDEX: readdata <= {16'h0000, compare_a[0]};
        tct_pkg::TIMER1_COMPARE_A_INDEX: readdata <= {16'h0000, compare_a[1]};
        tct_pkg::TIMER2_COMPARE_A_INDEX: readdata <= {16'h0000, compare_a[2]};
        tct_pkg::TIMER0_COMPARE_B_INDEX: readdata <= {16'h0000, compare_b[0]};
        tct_pkg::TIMER1_COMPARE_B_INDEX: readdata <= {16'h0000, compare_b[1]};
        default: readdata <= tct_pkg::UNMAPPED_READ;
      endcase
    end
  end

endmodule

/* File: tct_timer_control_props.sv */
`timescale 1ns/100ps
// Port-level checks on the timer block: bus answers, control read-back and request pulses.
module tct_timer_control_props (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic timer_input_zero,
  input wire logic timer_input_one,
  input wire logic [2:0] interrupt_request
);
  localparam logic [9:0] T0C = {tct_pkg::TIMER0_CONTROL_INDEX, 2'b00};
  localparam logic [9:0] T1C = {tct_pkg::TIMER1_CONTROL_INDEX, 2'b00};
  localparam logic [9:0] T2C = {tct_pkg::TIMER2_CONTROL_INDEX, 2'b00};
  logic is_ctl; // A control register read completes this cycle.
  logic flag_seen; // Last third-timer control read showed the max-count flag, no write since.
  logic mc_due; // A third-timer request pulse was seen, no control write since.
  logic mc_old; // Delayed copy, so the flag has surely landed in the read data.
  assign is_ctl = read && !waitrequest && (address == T0C || address == T1C || address == T2C);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // A read that completes at the given address.
  sequence s_rd(logic [9:0] a);
    read && !waitrequest && address == a;
  endsequence
  // Any write clears the sticky tracker; cheaper than decoding the written value.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flag_seen <= 1'b0;
    end else if (write && !waitrequest) begin
      flag_seen <= 1'b0;
    end else if (read && !waitrequest && address == T2C) begin
      flag_seen <= readdata[5];
    end
  end
  // Tracks that a max count happened on the third timer since its control was written.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mc_due <= 1'b0;
      mc_old <= 1'b0;
    end else if (write && !waitrequest && address == T2C) begin
      mc_due <= 1'b0;
      mc_old <= 1'b0;
    end else begin
      mc_due <= mc_due | interrupt_request[2];
      mc_old <= mc_due;
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0) !resetn |-> readdata == 32'h0000_0000 && interrupt_request == 3'h0)
    else $error("outputs not quiet in reset");
  a_gate_reads_zero: assert property (is_ctl |-> !readdata[14])
    else $error("gate bit read back as one");
  a_reserved_zero: assert property (is_ctl |-> readdata[11:6] == 6'h00 && readdata[31:16] == 16'h0000)
    else $error("reserved control bits not zero");
  a_irq_pulse: assert property (|interrupt_request[1:0] |=> (interrupt_request[1:0] & $past(interrupt_request[1:0])) == 2'h0)
    else $error("request longer than one cycle");
  a_t2_spacing: assert property (interrupt_request[2] |=> !interrupt_request[2] [*3])
    else $error("third timer requests closer than four clocks");
  a_wait_first: assert property ($rose(read || write) |-> waitrequest)
    else $error("no wait cycle on a new access");
  a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("more than one wait cycle");
  a_unmapped_zero: assert property (s_rd(10'h3FC) |-> readdata == tct_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");
  a_flag_sticky: assert property (s_rd(T2C) ##0 flag_seen |-> readdata[5])
    else $error("max-count flag dropped without a write");
  a_flag_on_max: assert property (s_rd(T2C) ##0 mc_old |-> readdata[5])
    else $error("max-count flag missing after a request");
endmodule
bind tct_timer_control tct_timer_control_props props_u (.clock(clock), .resetn(resetn),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .timer_input_zero(timer_input_zero), .timer_input_one(timer_input_one),
  .interrupt_request(interrupt_request));

/* File: tct_pin_partner.sv */
`timescale 1ns/100ps
// Far side: timer input pins idling high as pull-ups leave them, and an interrupt latch.
module tct_pin_partner (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [2:0] interrupt_request,
  output logic timer_input_zero,
  output logic timer_input_one
);
  int pulses [3]; // Requests held pending per timer until the bench clears them.
  initial begin
    timer_input_zero = 1'b1;
    timer_input_one = 1'b1;
  end
  // A request pulse stays pending whatever the timer does afterwards.
  always @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (resetn && interrupt_request[i]) begin
        pulses[i]++;
      end
    end
  end
  // Drives one pin level; called just after a rising edge.
  task automatic set_pin(input int ch, input logic v);
    if (ch == 0) begin
      timer_input_zero <= v;
    end else begin
      timer_input_one <= v;
    end
  endtask
  // Gives n rising edges, each level held four clocks so the synchroniser catches it.
  task automatic edges(input int ch, input int n);
    repeat (n) begin
      set_pin(ch, 1'b1);
      repeat (4) @(posedge clock);
      set_pin(ch, 1'b0);
      repeat (4) @(posedge clock);
    end
  endtask
endmodule

/* File: test_three_channel_timer_control.sv */
`timescale 1ns/100ps
// Bench: register calls over the Avalon port, pin edges through the partner model.
module test_three_channel_timer_control;
  localparam logic [9:0] T0C = {tct_pkg::TIMER0_CONTROL_INDEX, 2'b00};
  localparam logic [9:0] T1C = {tct_pkg::TIMER1_CONTROL_INDEX, 2'b00};
  localparam logic [9:0] T2C = {tct_pkg::TIMER2_CONTROL_INDEX, 2'b00};
  localparam logic [9:0] T1N = {tct_pkg::TIMER1_COUNT_INDEX, 2'b00};
  localparam logic [9:0] T2N = {tct_pkg::TIMER2_COUNT_INDEX, 2'b00};
  localparam logic [9:0] T0N = {tct_pkg::TIMER0_COUNT_INDEX, 2'b00};
  localparam logic [9:0] T0A = {tct_pkg::TIMER0_COMPARE_A_INDEX, 2'b00};
  localparam logic [9:0] T0B = {tct_pkg::TIMER0_COMPARE_B_INDEX, 2'b00};
  localparam logic [9:0] T1A = {tct_pkg::TIMER1_COMPARE_A_INDEX, 2'b00};
  localparam logic [9:0] T2A = {tct_pkg::TIMER2_COMPARE_A_INDEX, 2'b00};
  localparam int DIV = tct_pkg::INTERNAL_DIVIDE;
  logic clock = 1'b0;
  logic resetn;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic pin0, pin1;
  logic [2:0] interrupt_request;
  logic [15:0] rd, c1;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int ga, gb;
  // 25 MHz clock.
  always #20 clock = ~clock;
  tct_timer_control dut_u (.clock(clock), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .timer_input_zero(pin0), .timer_input_one(pin1),
    .interrupt_request(interrupt_request));
  tct_pin_partner partner_u (.clock(clock), .resetn(resetn),
    .interrupt_request(interrupt_request), .timer_input_zero(pin0), .timer_input_one(pin1));
  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles; a hang is cut off well beyond that.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  // Holds the request until the edge where waitrequest is low, then releases it.
  task automatic bus_write(input logic [9:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    writedata <= {16'h0000, d};
    write <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  // Read data are taken at the answering edge; they stand until the next read.
  task automatic bus_read(input logic [9:0] a, output logic [15:0] d);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    d = readdata[15:0];
    read <= 1'b0;
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts clocks up to the next request pulse of one timer.
  task automatic gap(input int ch, output int g);
    g = 0;
    do begin
      @(negedge clock);
      g++;
    end while (interrupt_request[ch] !== 1'b1);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  initial begin
    // Applied after every process waits on its edge, so the asynchronous reset is seen.
    resetn <= 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    bus_read(T0C, rd);
    check_val(rd, tct_pkg::CONTROL_RESET);
    bus_read(T1C, rd);
    check_val(rd, tct_pkg::CONTROL_RESET);
    bus_read(T2C, rd);
    check_val(rd, tct_pkg::CONTROL_RESET);
    bus_read(10'h3FC, rd);
    check_val(rd, 16'h0000);
    $display("test reset done");
    // Enable set without the gate bit must leave the timer still.
    bus_write(T2A, 16'h0003);
    bus_write(T2C, 16'hA000);
    idle(40);
    bus_read(T2N, rd);
    check_val(rd, 16'h0000);
    bus_write(T2C, 16'hE000);
    idle(60);
    check_val(16'(partner_u.pulses[2]), 16'h0001);
    bus_read(T2N, rd);
    check_val(rd, 16'h0000);
    $display("test one-shot done");
    bus_write(T2A, 16'h0005);
    bus_write(T2C, 16'hE001);
    gap(2, ga);
    gap(2, ga);
    check_val(16'(ga), 16'(5 * DIV));
    bus_read(T2C, rd);
    check_val(rd & 16'h4020, 16'h0020);
    bus_read(T2C, rd);
    check_val(rd & 16'h4020, 16'h0020);
    bus_write(T0A, 16'h0002);
    bus_write(T0C, 16'hE009);
    gap(0, ga);
    gap(0, ga);
    check_val(16'(ga), 16'(2 * 5 * DIV));
    $display("test prescale done");
    bus_write(T0B, 16'h0003);
    bus_write(T0C, 16'hE003);
    gap(0, ga);
    gap(0, ga);
    gap(0, gb);
    check_val(16'(ga + gb), 16'(5 * DIV));
    check_val(16'(ga > gb ? ga - gb : gb - ga), 16'(DIV));
    // The shorter run was compare A, so compare B is in use right after it.
    bus_read(T0C, rd);
    check_val(rd & 16'h1000, gb < ga ? 16'h1000 : 16'h0000);
    @(posedge clock);
    partner_u.set_pin(0, 1'b0);
    idle(8);
    bus_read(T0N, c1);
    idle(40);
    bus_read(T0N, rd);
    check_val(rd, c1);
    $display("test dual and gate done");
    // Stop first, then clear the flag, so no max count lands on the clearing write.
    bus_write(T2C, 16'h4000);
    bus_write(T2C, 16'h4000);
    bus_read(T2N, c1);
    idle(40);
    bus_read(T2N, rd);
    check_val(rd, c1);
    bus_read(T2C, rd);
    check_val(rd & 16'h0020, 16'h0000);
    // Requests raised before the timer was disabled are still pending at the latch.
    check_val(16'(partner_u.pulses[2] > 0), 16'h0001);
    @(posedge clock);
    partner_u.set_pin(1, 1'b0);
    idle(8);
    bus_write(T1A, 16'h0003);
    bus_write(T1C, 16'hE01D);
    partner_u.pulses[1] = 0;
    partner_u.edges(1, 5);
    check_val(16'(partner_u.pulses[1]), 16'h0001);
    bus_read(T1N, rd);
    check_val(rd, 16'h0002);
    $display("test external done");
    bus_write(T1A, 16'h0000);
    bus_write(T1C, 16'hC011);
    idle(100);
    bus_read(T1N, c1);
    partner_u.edges(1, 1);
    bus_read(T1N, rd);
    check_val({15'h0000, c1 > 16'h0010 && rd < 16'h0004}, 16'h0001);
    $display("test retrigger done");
    wrap_up();
  end
endmodule
